/* cidc_pkg.sv */
`default_nettype none

package cidc_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned CIDC_INSTR_W = 16;

    // ==========================================================
    // Condition codes
    localparam logic [3:0] COND_ZERO_SET = 4'h0;
    localparam logic [3:0] COND_ZERO_CLEAR = 4'h1;
    localparam logic [3:0] COND_CARRY_SET = 4'h2;
    localparam logic [3:0] COND_CARRY_CLEAR = 4'h3;
    localparam logic [3:0] COND_NEGATIVE = 4'h4;
    localparam logic [3:0] COND_POSITIVE_OR_ZERO = 4'h5;
    localparam logic [3:0] COND_OVERFLOW = 4'h6;
    localparam logic [3:0] COND_NO_OVERFLOW = 4'h7;
    localparam logic [3:0] COND_UNSIGNED_HIGHER = 4'h8;
    localparam logic [3:0] COND_UNSIGNED_LOWER_SAME = 4'h9;
    localparam logic [3:0] COND_SIGNED_GE = 4'hA;
    localparam logic [3:0] COND_SIGNED_LT = 4'hB;
    localparam logic [3:0] COND_SIGNED_GT = 4'hC;
    localparam logic [3:0] COND_SIGNED_LE = 4'hD;
    localparam logic [3:0] COND_ALWAYS = 4'hE;
    localparam logic [3:0] COND_SOFT_IRQ = 4'hF;

    // ==========================================================
    // Major opcode patterns
    localparam logic [1:0] OP_SHIFT_RESERVED = 2'h3;
    localparam logic [4:0] PAT_ADD_SUB = 5'h03;
    localparam logic [5:0] PAT_ALU = 6'h10;
    localparam logic [5:0] PAT_HIGH_REG = 6'h11;
    localparam logic [4:0] PAT_PC_LOAD = 5'h09;
    localparam logic [7:0] PAT_SP_ADJUST = 8'hB0;
    localparam logic [4:0] PAT_UNCOND_BRANCH = 5'h1C;

    // ==========================================================
    // Types
    typedef enum logic [4:0] {
        FMT_NONE, FMT_SHIFT, FMT_ADD_SUB, FMT_IMM8, FMT_ALU,
        FMT_HIGH_REG, FMT_PC_LOAD, FMT_REG_OFFSET, FMT_SIGN_EXT,
        FMT_IMM_OFFSET, FMT_HALF, FMT_SP_LOAD, FMT_LOAD_ADDR,
        FMT_SP_ADJUST, FMT_PUSH_POP, FMT_MULTI, FMT_COND_BRANCH,
        FMT_SOFT_IRQ, FMT_UNCOND_BRANCH, FMT_LONG_BRANCH
    } cidc_fmt_t;

    typedef struct packed {
        logic n;
        logic z;
        logic c;
        logic v;
    } cidc_flags_t;

    typedef struct packed {
        cidc_fmt_t fmt;
        logic [3:0] op;
        logic [3:0] rd;
        logic [3:0] rs;
        logic [2:0] ro;
        logic [10:0] imm;
        logic load;
        logic byte_sel;
        logic half_sel;
        logic sign_ext;
        logic imm_operand;
        logic sp_base;
        logic link_pc;
        logic high_half;
        logic [3:0] cond;
        logic cond_pass;
    } cidc_dec_t;

    localparam cidc_dec_t CIDC_DEC_RESET = '0;
    localparam cidc_flags_t CIDC_FLAGS_RESET = '0;

endpackage

`default_nettype wire

/* cidc_decode.sv */
`timescale 1ns/1ps
`default_nettype none

module cidc_decode
    import cidc_pkg::*;
#(
    parameter int unsigned INSTR_W = CIDC_INSTR_W
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Fetched instruction
    input wire logic instr_valid_i,
    input wire logic [INSTR_W-1:0] instr_i,
    // Flags and stand-alone condition test
    input wire cidc_flags_t flags_i,
    input wire logic [3:0] cond_code_i,
    // Decoded result, one cycle later
    output logic dec_valid_o,
    output cidc_dec_t dec_o,
    output logic cond_pass_o
);

    // ==========================================================
    // Parameter check
    // Field slicing below is fixed to a 16-bit word
    if (INSTR_W != 16) begin : g_bad_width
        $error("cidc_decode serves 16-bit instructions only");
    end

    // ==========================================================
    // Condition evaluator
    function automatic logic cond_eval(input logic [3:0] code,
                                       input cidc_flags_t f);
        logic pass;
        pass = 1'b0;
        case (code)
            COND_ZERO_SET: pass = f.z;
            COND_ZERO_CLEAR: pass = !f.z;
            COND_CARRY_SET: pass = f.c;
            COND_CARRY_CLEAR: pass = !f.c;
            COND_NEGATIVE: pass = f.n;
            COND_POSITIVE_OR_ZERO: pass = !f.n;
            COND_OVERFLOW: pass = f.v;
            COND_NO_OVERFLOW: pass = !f.v;
            COND_UNSIGNED_HIGHER: pass = f.c && !f.z;
            COND_UNSIGNED_LOWER_SAME: pass = !(f.c && !f.z);
            COND_SIGNED_GE: pass = (f.n == f.v);
            COND_SIGNED_LT: pass = (f.n != f.v);
            COND_SIGNED_GT: pass = !f.z && (f.n == f.v);
            COND_SIGNED_LE: pass = f.z || (f.n != f.v);
            COND_ALWAYS: pass = 1'b1;
            default: pass = 1'b0;
        endcase
        return pass;
    endfunction

    // ==========================================================
    // Instruction decode
    // Pure field extraction; no operand is checked for sense here
    cidc_dec_t dec;
    logic [15:0] w;

    always_comb begin
        w = instr_i[15:0];
        dec = CIDC_DEC_RESET;
        dec.rd = {1'b0, w[2:0]};
        dec.rs = {1'b0, w[5:3]};
        if (w[15:13] == 3'h0 && w[12:11] != OP_SHIFT_RESERVED) begin
            dec.fmt = FMT_SHIFT;
            dec.op = {2'h0, w[12:11]};
            dec.imm = {6'h00, w[10:6]};
        end else if (w[15:11] == PAT_ADD_SUB) begin
            dec.fmt = FMT_ADD_SUB;
            dec.imm_operand = w[10];
            dec.op = {3'h0, w[9]};
            dec.ro = w[8:6];
            dec.imm = {8'h00, w[8:6]};
        end else if (w[15:13] == 3'h1) begin
            dec.fmt = FMT_IMM8;
            dec.op = {2'h0, w[12:11]};
            dec.rd = {1'b0, w[10:8]};
            dec.rs = 4'h0;
            dec.imm = {3'h0, w[7:0]};
        end else if (w[15:10] == PAT_ALU) begin
            dec.fmt = FMT_ALU;
            dec.op = w[9:6];
        end else if (w[15:10] == PAT_HIGH_REG) begin
            dec.fmt = FMT_HIGH_REG;
            dec.op = {2'h0, w[9:8]};
            dec.rd = {w[7], w[2:0]};
            dec.rs = {w[6], w[5:3]};
        end else if (w[15:11] == PAT_PC_LOAD) begin
            dec.fmt = FMT_PC_LOAD;
            dec.load = 1'b1;
            dec.rd = {1'b0, w[10:8]};
            dec.rs = 4'h0;
            dec.imm = {3'h0, w[7:0]};
        end else if (w[15:12] == 4'h5) begin
            dec.ro = w[8:6];
            dec.rs = {1'b0, w[5:3]};
            if (!w[9]) begin
                dec.fmt = FMT_REG_OFFSET;
                dec.load = w[11];
                dec.byte_sel = w[10];
            end else begin
                // H=0,S=0 store half; H=1,S=0 load half;
                // H=0,S=1 signed byte; H=1,S=1 signed half
                dec.fmt = FMT_SIGN_EXT;
                dec.half_sel = w[11];
                dec.sign_ext = w[10];
                dec.load = w[11] || w[10];
                dec.byte_sel = w[10] && !w[11];
            end
        end else if (w[15:13] == 3'h3) begin
            dec.fmt = FMT_IMM_OFFSET;
            dec.byte_sel = w[12];
            dec.load = w[11];
            dec.imm = {6'h00, w[10:6]};
        end else if (w[15:12] == 4'h8) begin
            dec.fmt = FMT_HALF;
            dec.half_sel = 1'b1;
            dec.load = w[11];
            dec.imm = {6'h00, w[10:6]};
        end else if (w[15:12] == 4'h9) begin
            dec.fmt = FMT_SP_LOAD;
            dec.load = w[11];
            dec.sp_base = 1'b1;
            dec.rd = {1'b0, w[10:8]};
            dec.rs = 4'h0;
            dec.imm = {3'h0, w[7:0]};
        end else if (w[15:12] == 4'hA) begin
            dec.fmt = FMT_LOAD_ADDR;
            dec.sp_base = w[11];
            dec.rd = {1'b0, w[10:8]};
            dec.rs = 4'h0;
            dec.imm = {3'h0, w[7:0]};
        end else if (w[15:8] == PAT_SP_ADJUST) begin
            dec.fmt = FMT_SP_ADJUST;
            dec.sign_ext = w[7];
            dec.sp_base = 1'b1;
            dec.rd = 4'h0;
            dec.rs = 4'h0;
            dec.imm = {4'h0, w[6:0]};
        end else if (w[15:12] == 4'hB && w[10:9] == 2'h2) begin
            dec.fmt = FMT_PUSH_POP;
            dec.load = w[11];
            dec.link_pc = w[8];
            dec.sp_base = 1'b1;
            dec.rd = 4'h0;
            dec.rs = 4'h0;
            dec.imm = {3'h0, w[7:0]};
        end else if (w[15:12] == 4'hC) begin
            dec.fmt = FMT_MULTI;
            dec.load = w[11];
            dec.rd = 4'h0;
            dec.rs = {1'b0, w[10:8]};
            dec.imm = {3'h0, w[7:0]};
        end else if (w[15:12] == 4'hD) begin
            dec.rd = 4'h0;
            dec.rs = 4'h0;
            dec.cond = w[11:8];
            dec.imm = {3'h0, w[7:0]};
            if (w[11:8] == COND_SOFT_IRQ) begin
                dec.fmt = FMT_SOFT_IRQ;
            end else begin
                dec.fmt = FMT_COND_BRANCH;
                dec.sign_ext = 1'b1;
                dec.cond_pass = cond_eval(w[11:8], flags_i);
            end
        end else if (w[15:11] == PAT_UNCOND_BRANCH) begin
            dec.fmt = FMT_UNCOND_BRANCH;
            dec.sign_ext = 1'b1;
            dec.rd = 4'h0;
            dec.rs = 4'h0;
            dec.imm = w[10:0];
        end else if (w[15:12] == 4'hF) begin
            dec.fmt = FMT_LONG_BRANCH;
            dec.high_half = !w[11];
            dec.link_pc = 1'b1;
            dec.rd = 4'h0;
            dec.rs = 4'h0;
            dec.imm = w[10:0];
        end else begin
            // Undefined encodings report no format and no fields
            dec = CIDC_DEC_RESET;
        end
    end

    // ==========================================================
    // Output stage
    // Registered so the execute stage sees a clean word
    logic next_dec_valid;
    cidc_dec_t next_dec;
    logic next_cond_pass;

    always_comb begin
        next_dec_valid = instr_valid_i;
        next_dec = instr_valid_i ? dec : CIDC_DEC_RESET;
        next_cond_pass = cond_eval(cond_code_i, flags_i);
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            dec_valid_o <= 1'b0;
            dec_o <= CIDC_DEC_RESET;
            cond_pass_o <= 1'b0;
        end else begin
            dec_valid_o <= next_dec_valid;
            dec_o <= next_dec;
            cond_pass_o <= next_cond_pass;
        end
    end

    // ==========================================================
    // Checks
    logic [15:0] last_w;
    cidc_flags_t last_f;
    logic [3:0] last_code;

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            last_w <= 16'h0000;
            last_f <= CIDC_FLAGS_RESET;
            last_code <= 4'h0;
        end else begin
            last_w <= instr_i[15:0];
            last_f <= flags_i;
            last_code <= cond_code_i;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence issue_s;
        instr_valid_i ##1 dec_valid_o;
    endsequence

    sequence cond_seen_s(logic [3:0] c);
        cond_code_i == c ##1 1'b1;
    endsequence

    valid_latency_a: assert property (instr_valid_i |=> dec_valid_o)
        else $error("decode valid did not follow request");
    shift_fields_a: assert property (
        issue_s ##0 (last_w[15:13] == 3'h0 && last_w[12:11] != 2'h3)
        |-> dec_o.fmt == FMT_SHIFT && dec_o.imm[4:0] == last_w[10:6]
            && dec_o.rs[2:0] == last_w[5:3] && dec_o.rd[2:0] == last_w[2:0])
        else $error("shift fields wrong");
    add_sub_a: assert property (
        issue_s ##0 (last_w[15:11] == 5'h03) |-> dec_o.fmt == FMT_ADD_SUB
            && dec_o.imm_operand == last_w[10] && dec_o.op[0] == last_w[9])
        else $error("add/subtract fields wrong");
    imm8_fields_a: assert property (
        issue_s ##0 (last_w[15:13] == 3'h1) |-> dec_o.fmt == FMT_IMM8
            && dec_o.rd[2:0] == last_w[10:8] && dec_o.imm[7:0] == last_w[7:0])
        else $error("immediate fields wrong");
    high_reg_a: assert property (
        issue_s ##0 (last_w[15:10] == 6'h11)
        |-> dec_o.rd == {last_w[7], last_w[2:0]}
            && dec_o.rs == {last_w[6], last_w[5:3]})
        else $error("high register extension wrong");
    sign_ext_a: assert property (
        issue_s ##0 (last_w[15:12] == 4'h5 && last_w[9])
        |-> dec_o.fmt == FMT_SIGN_EXT && dec_o.half_sel == last_w[11]
            && dec_o.sign_ext == last_w[10])
        else $error("sign-extend transfer fields wrong");
    soft_irq_a: assert property (
        issue_s ##0 (last_w[15:8] == 8'hDF)
        |-> dec_o.fmt == FMT_SOFT_IRQ && !dec_o.cond_pass)
        else $error("all-ones condition not a soft interrupt");
    long_branch_a: assert property (
        issue_s ##0 (last_w[15:12] == 4'hF)
        |-> dec_o.high_half != last_w[11] && dec_o.imm == last_w[10:0])
        else $error("long branch half wrong");
    cond_hi_a: assert property (
        cond_seen_s(4'h8) |-> cond_pass_o == (last_f.c && !last_f.z))
        else $error("unsigned higher test wrong");
    cond_gt_a: assert property (
        cond_seen_s(4'hC)
        |-> cond_pass_o == (!last_f.z && last_f.n == last_f.v))
        else $error("greater-than test wrong");
    cond_le_a: assert property (
        cond_seen_s(4'hD)
        |-> cond_pass_o == (last_f.z || last_f.n != last_f.v))
        else $error("less-or-equal test wrong");
    cond_always_a: assert property (
        cond_seen_s(4'hE) |-> cond_pass_o)
        else $error("always condition failed");
    cond_ge_a: assert property (
        cond_seen_s(4'hA) |-> cond_pass_o == (last_f.n == last_f.v))
        else $error("greater-or-equal test wrong");
    // Registered code and result line up, so no delay is needed here
    cond_lt_a: assert property (
        last_code == COND_SIGNED_LT |-> cond_pass_o == (last_f.n != last_f.v))
        else $error("less-than test wrong");
    cond_cc_a: assert property (
        last_code == COND_CARRY_CLEAR |-> cond_pass_o == !last_f.c)
        else $error("carry clear test wrong");

endmodule

`default_nettype wire

/* cidc_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cidc_fetch_model
    import cidc_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Bench request
    input wire logic issue_i,
    input wire logic [CIDC_INSTR_W-1:0] word_i,
    // Toward the decoder
    output logic instr_valid_o,
    output logic [CIDC_INSTR_W-1:0] instr_o
);
    // ==========================================================
    // Fetch slot
    logic next_valid;
    logic [CIDC_INSTR_W-1:0] next_instr;

    // Idle slots show the flipped last word, so each idle slot differs from the slot before it
    always_comb begin
        next_valid = issue_i;
        next_instr = issue_i ? word_i : ~instr_o;
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            instr_valid_o <= 1'b0;
            instr_o <= 16'hA5C3;
        end else begin
            instr_valid_o <= next_valid;
            instr_o <= next_instr;
        end
    end
endmodule

`default_nettype wire

/* test_compact_isa_decode_and_cond.sv */
`timescale 1ns/1ps
`default_nettype none

module test_compact_isa_decode_and_cond;
    import cidc_pkg::*;

    // ==========================================================
    // Signals
    logic clk;
    logic sys_rst;
    logic issue;
    logic [15:0] word;
    logic instr_valid;
    logic [15:0] instr;
    cidc_flags_t flags;
    logic [3:0] cond_code;
    logic dec_valid;
    cidc_dec_t dec;
    logic cond_pass;
    int error_cnt = 0;
    int num_checks = 0;

    always #2 clk = ~clk;

    cidc_fetch_model fetch (.clk_i(clk), .sys_rst_i(sys_rst),
        .issue_i(issue), .word_i(word),
        .instr_valid_o(instr_valid), .instr_o(instr));

    cidc_decode DUT (.clk_i(clk), .sys_rst_i(sys_rst),
        .instr_valid_i(instr_valid), .instr_i(instr),
        .flags_i(flags), .cond_code_i(cond_code),
        .dec_valid_o(dec_valid), .dec_o(dec), .cond_pass_o(cond_pass));

    // ==========================================================
    // Helpers
    task automatic check(input string name, input logic [63:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    function automatic logic cond_ok(input logic [3:0] c, cidc_flags_t f);
        case (c)
            4'h0: return f.z;
            4'h1: return !f.z;
            4'h2: return f.c;
            4'h3: return !f.c;
            4'h4: return f.n;
            4'h5: return !f.n;
            4'h6: return f.v;
            4'h7: return !f.v;
            4'h8: return f.c && !f.z;
            4'h9: return !f.c || f.z;
            4'hA: return f.n == f.v;
            4'hB: return f.n != f.v;
            4'hC: return !f.z && (f.n == f.v);
            4'hD: return f.z || (f.n != f.v);
            4'hE: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Issue one word, wait the fixed latency, compare every named field; cond is compared for conditional branches only
    task automatic dc(input logic [15:0] w, input cidc_fmt_t fm,
        input logic [3:0] op, rd, rs, input logic [10:0] imm,
        input logic [2:0] fl);
        logic [2:0] ro;
        logic pass;
        logic [2:0] misc;
        ro = (fm == FMT_ADD_SUB || fm == FMT_REG_OFFSET ||
            fm == FMT_SIGN_EXT) ? w[8:6] : 3'h0;
        misc[2] = fm == FMT_SP_LOAD || fm == FMT_SP_ADJUST ||
            fm == FMT_PUSH_POP || (fm == FMT_LOAD_ADDR && w[11]);
        misc[1] = fm == FMT_HALF || (fm == FMT_SIGN_EXT && w[11]);
        misc[0] = fm == FMT_ADD_SUB && w[10];
        pass = (fm == FMT_COND_BRANCH) && cond_ok(w[11:8], flags);
        @(posedge clk);
        issue <= 1'b1;
        word <= w;
        @(posedge clk);
        issue <= 1'b0;
        @(posedge clk);
        #1;
        check("dec_valid", 64'(dec_valid), 64'h1);
        check("fmt", 64'(dec.fmt), 64'(fm));
        check("op", 64'(dec.op), 64'(op));
        check("rd", 64'(dec.rd), 64'(rd));
        check("rs", 64'(dec.rs), 64'(rs));
        check("ro", 64'(dec.ro), 64'(ro));
        check("imm", 64'(dec.imm), 64'(imm));
        check("flg",
            64'({dec.load, dec.byte_sel, dec.sign_ext}), 64'(fl));
        check("misc",
            64'({dec.sp_base, dec.half_sel, dec.imm_operand}), 64'(misc));
        check("link", 64'(dec.link_pc), 64'((fm == FMT_PUSH_POP && w[8])
            || fm == FMT_LONG_BRANCH));
        check("half", 64'(dec.high_half),
            64'(fm == FMT_LONG_BRANCH && !w[11]));
        check("br_pass", 64'(dec.cond_pass), 64'(pass));
        if (fm == FMT_COND_BRANCH) begin
            check("cond", 64'(dec.cond), 64'(w[11:8]));
        end
        if (fm == FMT_NONE) begin
            check("undef", 64'(dec), 64'(CIDC_DEC_RESET));
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_reset();
        @(posedge clk);
        #1;
        check("rst_valid", 64'(dec_valid), 64'h0);
        check("rst_pass", 64'(cond_pass), 64'h0);
        @(posedge clk);
        cond_code <= 4'hE;
        repeat (2) @(posedge clk);
        #1;
        check("always", 64'(cond_pass), 64'h1);
        // Reset moves on the edge so the checks see it in the same cycle
        @(posedge clk);
        sys_rst <= 1'b1;
        cond_code <= 4'h0;
        #1;
        check("mid_rst", 64'(cond_pass), 64'h0);
        check("mid_dec", 64'(dec), 64'(CIDC_DEC_RESET));
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        #1;
        check("rel_pass", 64'(cond_pass), 64'h0);
        $display("test_reset done");
    endtask

    // Every code against every flag combination
    task automatic test_cond();
        for (int c = 0; c < 16; c++) begin
            for (int f = 0; f < 16; f++) begin
                @(posedge clk);
                cond_code <= 4'(c);
                flags <= cidc_flags_t'(4'(f));
                @(posedge clk);
                #1;
                check("cond_pass", 64'(cond_pass),
                    64'(cond_ok(4'(c), cidc_flags_t'(4'(f)))));
            end
        end
        $display("test_cond done");
    endtask

    task automatic test_formats();
        @(posedge clk);
        flags <= 4'h4;
        dc(16'h0DAB,FMT_SHIFT,4'h1,4'h3,4'h5,11'h016,3'h0);
        dc(16'h1F97,FMT_ADD_SUB,4'h1,4'h7,4'h2,11'h006,3'h0);
        dc(16'h2A05,FMT_IMM8,4'h1,4'h2,4'h0,11'h005,3'h0);
        dc(16'h434E,FMT_ALU,4'hD,4'h6,4'h1,11'h000,3'h0);
        dc(16'h469C,FMT_HIGH_REG,4'h2,4'hC,4'h3,11'h000,3'h0);
        dc(16'h457C,FMT_HIGH_REG,4'h1,4'h4,4'hF,11'h000,3'h0);
        dc(16'h4D3C,FMT_PC_LOAD,4'h0,4'h5,4'h0,11'h03C,3'h4);
        dc(16'h93FF,FMT_SP_LOAD,4'h0,4'h3,4'h0,11'h0FF,3'h0);
        dc(16'hAC80,FMT_LOAD_ADDR,4'h0,4'h4,4'h0,11'h080,3'h0);
        dc(16'h58D1,FMT_REG_OFFSET,4'h0,4'h1,4'h2,11'h000,3'h4);
        dc(16'h55AA,FMT_REG_OFFSET,4'h0,4'h2,4'h5,11'h000,3'h2);
        dc(16'h5667,FMT_SIGN_EXT,4'h0,4'h7,4'h4,11'h000,3'h7);
        dc(16'h5A98,FMT_SIGN_EXT,4'h0,4'h0,4'h3,11'h000,3'h4);
        dc(16'h53CA,FMT_SIGN_EXT,4'h0,4'h2,4'h1,11'h000,3'h0);
        dc(16'h5E00,FMT_SIGN_EXT,4'h0,4'h0,4'h0,11'h000,3'h5);
        dc(16'h77C1,FMT_IMM_OFFSET,4'h0,4'h1,4'h0,11'h01F,3'h2);
        dc(16'h887E,FMT_HALF,4'h0,4'h6,4'h7,11'h001,3'h4);
        dc(16'hB083,FMT_SP_ADJUST,4'h0,4'h0,4'h0,11'h003,3'h1);
        dc(16'hBDA5,FMT_PUSH_POP,4'h0,4'h0,4'h0,11'h0A5,3'h4);
        dc(16'hB200,FMT_NONE,4'h0,4'h0,4'h0,11'h000,3'h0);
        dc(16'hC63C,FMT_MULTI,4'h0,4'h0,4'h6,11'h03C,3'h0);
        dc(16'hD0F0,FMT_COND_BRANCH,4'h0,4'h0,4'h0,11'h0F0,3'h1);
        dc(16'hD17F,FMT_COND_BRANCH,4'h0,4'h0,4'h0,11'h07F,3'h1);
        dc(16'hDF42,FMT_SOFT_IRQ,4'h0,4'h0,4'h0,11'h042,3'h0);
        dc(16'hE5A5,FMT_UNCOND_BRANCH,4'h0,4'h0,4'h0,11'h5A5,3'h1);
        dc(16'hE800,FMT_NONE,4'h0,4'h0,4'h0,11'h000,3'h0);
        dc(16'hF7FF,FMT_LONG_BRANCH,4'h0,4'h0,4'h0,11'h7FF,3'h0);
        dc(16'hFC01,FMT_LONG_BRANCH,4'h0,4'h0,4'h0,11'h401,3'h0);
        $display("test_formats done");
    endtask

    // Two words back to back, then an idle slot holding a decodable word
    task automatic test_burst();
        @(posedge clk);
        issue <= 1'b1;
        word <= 16'h2A05;
        @(posedge clk);
        word <= 16'hE5A5;
        @(posedge clk);
        issue <= 1'b0;
        #1;
        check("burst0", 64'(dec.fmt), 64'(FMT_IMM8));
        @(posedge clk);
        #1;
        check("burst1", 64'(dec.fmt), 64'(FMT_UNCOND_BRANCH));
        @(posedge clk);
        #1;
        check("idle_v", 64'(dec_valid), 64'h0);
        check("idle_d", 64'(dec), 64'(CIDC_DEC_RESET));
        $display("test_burst done");
    endtask

    // ==========================================================
    // Run control
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        complete_run();
    end

    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        issue = 1'b0;
        word = 16'h0000;
        flags = CIDC_FLAGS_RESET;
        cond_code = 4'h0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        test_reset();
        test_cond();
        test_formats();
        test_burst();
        complete_run();
    end
endmodule

`default_nettype wire
